// ### pkg/pwm_pkg.sv
// Summary of operation
// [RQ1] The counting clock is the system clock or a timer overflow pulse, divided by a power-of-two ratio of 1 to 128.
// [RQ2] One 16-bit counter, bounded by a 16-bit period split into low and high bytes, is shared by all six channels.
// [RQ3] Each of the six channels compares its own 16-bit duty value against the shared counter.
// [RQ4] In group mode channels 2 and 4 use the duty of channel 0, channels 3 and 5 that of channel 1.
// [RQ5] Software must set the pin directions itself; starting the generator does not change them.
// [RQ6] Raw waves pass through pairing, dead time, masking, fault brake and polarity, then a per-pin PWM/GPIO select.
// [RQ7] Writing one to the counter clear bit resets the counter to zero.
// [RQ8] After clear and setup, setting the run bit starts the counter and waveforms appear.
// [RQ9] Period and duty are double buffered and the working copies change only at a period end after a reload request; the code also copies at once while stopped.
// [RQ10] Hardware clears the reload request once the transfer is done; software polls for it.
// [RQ11] Software must not change generator control registers while the reload request still reads one.
// [RQ12] One waveform type bit selects edge-aligned or center-aligned counting.
// [RQ13] Edge-aligned counting runs from zero up to the period and restarts at zero.
// [RQ14] Edge-aligned waves set at count zero and clear when the count equals the duty.
// [RQ15] Center-aligned counting runs up to the period and back to zero; waves clear on the up match, set on the down.
// [RQ16] A two-bit pairing field selects independent (00), complementary (01) or synchronous (10) pairs.
package pwm_pkg;

  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CLKDIV = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_DUTY [0:5] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  localparam logic [7:0] OFF_DEADTIME = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2C;
  localparam logic [7:0] OFF_FAULT = 8'h30;
  localparam logic [7:0] OFF_OUTCFG = 8'h34;
  localparam logic [7:0] OFF_COUNT = 8'h38;

  localparam int CTRL0_RUN = 7;
  localparam int CTRL0_LOAD = 6;
  localparam int CTRL0_CLR = 4;
  localparam int CTRL1_PAIR_LSB = 6;
  localparam int CTRL1_GROUP = 5;
  localparam int CTRL1_TYPE = 4;
  localparam int CTRL1_FBEN = 3;
  localparam int CLKDIV_SRC = 3;
  localparam int FAULT_POL = 6;
  localparam int FAULT_FLAG = 7;
  localparam int HI_LANE_LSB = 8;
  localparam int DT_EN_LSB = 16;
  localparam int COUNT_STATE_LSB = 16;

  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [3:0] FB_DEBOUNCE_CYC = 4'h8;

  typedef enum logic [1:0] {
    PAIR_INDEP = 2'b00,
    PAIR_COMP = 2'b01,
    PAIR_SYNC = 2'b10
  } pair_mode_t;

  typedef enum logic [2:0] {
    CNT_STOP = 3'b001,
    CNT_UP = 3'b010,
    CNT_DOWN = 3'b100
  } cnt_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

endpackage

// ### verilog/prescale_tick.sv
`timescale 1ns/1ps
module prescale_tick #(
  parameter int RATIO_LOG2_MAX = 7
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic use_timer,
  input wire logic [2:0] ratio_log2,
  input wire logic timer_overflow,
  output logic tick_q
);
  import pwm_pkg::*;

  if (RATIO_LOG2_MAX < 1 || RATIO_LOG2_MAX > 7) begin : g_bad_ratio
    $error("prescale_tick: ratio range must be 1..7");
  end

  logic [RATIO_LOG2_MAX-1:0] cnt_q;
  logic [RATIO_LOG2_MAX-1:0] limit;
  logic src;

  // timer overflow arrives as a one-cycle pulse in the system clock domain
  assign src = use_timer ? timer_overflow : 1'b1;
  assign limit = RATIO_LOG2_MAX'((32'h0000_0001 << ratio_log2) - 32'h0000_0001);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (src) begin
        // >= so a ratio lowered mid-count never runs the counter round
        if (cnt_q >= limit) begin // [RQ1]
          cnt_q <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_tick_div2;
    tick_q && !use_timer && ratio_log2 != 3'd0 && $stable(ratio_log2) |=> !tick_q;
  endproperty
  a_tick_div2: assert property (p_tick_div2) else $error("tick too soon after a tick"); // [RQ1]

  property p_tick_div1;
    !use_timer && ratio_log2 == 3'd0 ##1 !use_timer && ratio_log2 == 3'd0 |=> tick_q;
  endproperty
  a_tick_div1: assert property (p_tick_div1) else $error("tick missing at ratio 1"); // [RQ1]

endmodule

// ### verilog/six_channel_pwm_generator.sv
`timescale 1ns/1ps
module six_channel_pwm_generator #(
  parameter int CNT_W = 16,
  parameter int NUM_OUT = 6,
  parameter int DT_W = 9
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire pwm_pkg::avmm_req_t av_req,
  output logic [31:0] av_readdata_q,
  output logic av_waitrequest_q,
  input wire logic timer_overflow,
  input wire logic fault_pin,
  input wire logic [NUM_OUT-1:0] gpio_level,
  output logic [NUM_OUT-1:0] pin_level_q
);
  import pwm_pkg::*;

  if (CNT_W != 16 || NUM_OUT != 6 || DT_W < 1 || DT_W > 16) begin : g_bad_param
    $error("six_channel_pwm_generator: unsupported parameter set");
  end

  logic bus_take;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [31:0] wd;
  logic [3:0] be;
  logic [31:0] rdata_d;

  logic run_q;
  logic load_q;
  logic brake_q;
  pair_mode_t pair_mode_q;
  logic group_q;
  logic wtype_q;
  logic fb_en_q;
  logic src_sel_q;
  logic [2:0] ratio_q;
  logic [CNT_W-1:0] period_sh_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] duty_sh_q [NUM_OUT];
  logic [CNT_W-1:0] duty_q [NUM_OUT];
  logic [CNT_W-1:0] duty_eff [NUM_OUT];
  logic [DT_W-1:0] dt_val_q;
  logic [2:0] dt_en_q;
  logic [NUM_OUT-1:0] mask_en_q;
  logic [NUM_OUT-1:0] mask_lvl_q;
  logic [NUM_OUT-1:0] fb_data_q;
  logic fb_pol_q;
  logic fb_flag_q;
  logic [NUM_OUT-1:0] inv_q;
  logic [NUM_OUT-1:0] pin_sel_q;

  logic ctrl0_wr;
  logic run_set;
  logic load_set;
  logic clr_req;
  logic tick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  cnt_state_t state_q;
  cnt_state_t state_d;
  logic period_end;
  logic load_apply;
  logic cnt_step;
  logic [3:0] fb_cnt_q;
  logic fb_active;
  logic fb_trip;
  logic [NUM_OUT-1:0] raw_q;
  logic [NUM_OUT-1:0] pair_w;
  logic [NUM_OUT-1:0] dt_w;
  logic [NUM_OUT-1:0] ctl_w;

  assign wd = av_req.writedata;
  assign be = av_req.byteenable;
  assign wr_idx = av_req.address[7:2];
  assign bus_take = (av_req.read | av_req.write) & av_waitrequest_q;
  assign wr_en = av_req.write & ~av_waitrequest_q;

  function automatic logic hit(input logic [7:0] off);
    return wr_en && (wr_idx == off[7:2]);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] lanes);
    logic [15:0] r;
    r = old_v;
    if (lanes[0]) r[7:0] = new_v[7:0];
    if (lanes[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction

  // every access waits exactly one cycle: the request is registered first, then answered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      av_waitrequest_q <= 1'b1;
      av_readdata_q <= '0;
    end else begin
      av_waitrequest_q <= ~bus_take;
      if (bus_take) begin
        av_readdata_q <= av_req.read ? rdata_d : '0;
      end
    end
  end

  assign ctrl0_wr = hit(OFF_CTRL0) & be[0];
  assign run_set = ctrl0_wr & wd[CTRL0_RUN];
  assign load_set = ctrl0_wr & wd[CTRL0_LOAD];
  assign clr_req = ctrl0_wr & wd[CTRL0_CLR];

  // fault wins over a simultaneous run write so a trip can never be masked
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      brake_q <= 1'b0;
    end else if (fb_trip) begin
      run_q <= 1'b0; // [RQ6]
      brake_q <= 1'b1;
    end else if (ctrl0_wr) begin
      run_q <= wd[CTRL0_RUN]; // [RQ8]
      if (wd[CTRL0_RUN]) brake_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      load_q <= 1'b0;
    end else if (load_set) begin
      load_q <= 1'b1;
    end else if (load_apply) begin
      load_q <= 1'b0; // [RQ10]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pair_mode_q <= PAIR_INDEP;
      group_q <= 1'b0;
      wtype_q <= 1'b0;
      fb_en_q <= 1'b0;
      src_sel_q <= 1'b0;
      ratio_q <= RATIO_RST;
      dt_val_q <= '0;
      dt_en_q <= '0;
      mask_en_q <= '0;
      mask_lvl_q <= '0;
      fb_data_q <= '0;
      fb_pol_q <= 1'b0;
      inv_q <= '0;
      pin_sel_q <= '0;
    end else begin
      if (hit(OFF_CTRL1) && be[0]) begin
        pair_mode_q <= pair_mode_t'(wd[CTRL1_PAIR_LSB +: 2]); // [RQ16]
        group_q <= wd[CTRL1_GROUP]; // [RQ4]
        wtype_q <= wd[CTRL1_TYPE]; // [RQ12]
        fb_en_q <= wd[CTRL1_FBEN];
      end
      if (hit(OFF_CLKDIV) && be[0]) begin
        src_sel_q <= wd[CLKDIV_SRC]; // [RQ1]
        ratio_q <= wd[2:0];
      end
      if (hit(OFF_DEADTIME)) begin
        dt_val_q <= DT_W'(merge16(16'(dt_val_q), wd[15:0], be[1:0]));
        if (be[2]) dt_en_q <= wd[DT_EN_LSB +: 3];
      end
      if (hit(OFF_MASK)) begin
        if (be[0]) mask_en_q <= wd[NUM_OUT-1:0];
        if (be[1]) mask_lvl_q <= wd[HI_LANE_LSB +: NUM_OUT];
      end
      if (hit(OFF_FAULT) && be[0]) begin
        fb_data_q <= wd[NUM_OUT-1:0];
        fb_pol_q <= wd[FAULT_POL];
      end
      if (hit(OFF_OUTCFG)) begin
        if (be[0]) inv_q <= wd[NUM_OUT-1:0];
        if (be[1]) pin_sel_q <= wd[HI_LANE_LSB +: NUM_OUT];
      end
    end
  end

  // shadow copies take writes at any time; working copies only move on load_apply
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_sh_q <= PERIOD_RST;
      period_q <= PERIOD_RST;
      for (int i = 0; i < NUM_OUT; i++) begin
        duty_sh_q[i] <= DUTY_RST;
        duty_q[i] <= DUTY_RST;
      end
    end else begin
      if (hit(OFF_PERIOD)) begin
        period_sh_q <= merge16(period_sh_q, wd[15:0], be[1:0]); // [RQ2]
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        if (hit(OFF_DUTY[i])) duty_sh_q[i] <= merge16(duty_sh_q[i], wd[15:0], be[1:0]); // [RQ3]
      end
      if (load_apply) begin
        period_q <= period_sh_q; // [RQ9]
        for (int i = 0; i < NUM_OUT; i++) duty_q[i] <= duty_sh_q[i];
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    case (wr_idx)
      OFF_CTRL0[7:2]: begin
        rdata_d[CTRL0_RUN] = run_q;
        rdata_d[CTRL0_LOAD] = load_q; // [RQ10]
      end
      OFF_CTRL1[7:2]: begin
        rdata_d[CTRL1_PAIR_LSB +: 2] = pair_mode_q;
        rdata_d[CTRL1_GROUP] = group_q;
        rdata_d[CTRL1_TYPE] = wtype_q;
        rdata_d[CTRL1_FBEN] = fb_en_q;
      end
      OFF_CLKDIV[7:2]: rdata_d[3:0] = {src_sel_q, ratio_q};
      OFF_PERIOD[7:2]: rdata_d[15:0] = period_sh_q;
      OFF_DEADTIME[7:2]: rdata_d = {13'h0000, dt_en_q, 7'h00, dt_val_q};
      OFF_MASK[7:2]: rdata_d = {18'h0_0000, mask_lvl_q, 2'h0, mask_en_q};
      OFF_FAULT[7:2]: rdata_d = {24'h00_0000, fb_flag_q, fb_pol_q, fb_data_q};
      OFF_OUTCFG[7:2]: rdata_d = {18'h0_0000, pin_sel_q, 2'h0, inv_q};
      OFF_COUNT[7:2]: rdata_d = {13'h0000, state_q, cnt_q};
      default: begin
        for (int i = 0; i < NUM_OUT; i++) begin
          if (wr_idx == OFF_DUTY[i][7:2]) rdata_d[15:0] = duty_sh_q[i];
        end
      end
    endcase
  end

  prescale_tick #(
    .RATIO_LOG2_MAX(7)
  ) u_prescale (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .use_timer(src_sel_q),
    .ratio_log2(ratio_q),
    .timer_overflow(timer_overflow),
    .tick_q(tick)
  );

  // one shared counter for all channels
  always_comb begin
    cnt_d = cnt_q;
    state_d = state_q;
    period_end = 1'b0;
    if (fb_trip || clr_req) begin
      cnt_d = '0; // [RQ7]
      state_d = (fb_trip || !run_q) ? CNT_STOP : CNT_UP;
    end else if (!run_q) begin
      state_d = CNT_STOP;
    end else begin
      case (state_q)
        CNT_STOP: state_d = CNT_UP; // [RQ8]
        CNT_UP: begin
          if (tick) begin
            if (cnt_q >= period_q) begin
              if (!wtype_q || period_q == '0) begin
                cnt_d = '0; // [RQ13]
                period_end = 1'b1;
              end else begin
                state_d = CNT_DOWN; // [RQ15]
                cnt_d = period_q - 1'b1;
              end
            end else begin
              cnt_d = cnt_q + 1'b1; // [RQ2]
            end
          end
        end
        CNT_DOWN: begin
          if (tick) begin
            if (cnt_q == '0 || !wtype_q) begin
              state_d = CNT_UP; // [RQ12]
              cnt_d = wtype_q ? CNT_W'(1) : '0;
              period_end = 1'b1;
            end else begin
              cnt_d = cnt_q - 1'b1; // [RQ15]
            end
          end
        end
        default: state_d = CNT_STOP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      state_q <= CNT_STOP;
    end else begin
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

  // a stopped generator has no period end to wait for, so the copy happens at once
  assign load_apply = load_q & (period_end | (state_q == CNT_STOP)); // [RQ9]
  assign cnt_step = tick & run_q & (state_q != CNT_STOP) & ~clr_req & ~fb_trip;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_ch
    assign duty_eff[i] = (group_q && i >= 2) ? duty_q[i % 2] : duty_q[i]; // [RQ4]
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        raw_q[i] <= 1'b0;
      end else if (clr_req || fb_trip) begin
        raw_q[i] <= (duty_eff[i] != '0);
      end else if (cnt_step) begin
        if (!wtype_q) begin
          if (cnt_d == duty_eff[i]) raw_q[i] <= 1'b0; // [RQ14]
          else if (cnt_d == '0) raw_q[i] <= 1'b1; // [RQ14]
        end else if (duty_eff[i] == '0) begin
          raw_q[i] <= 1'b0;
        end else if (state_d == CNT_UP && cnt_d >= duty_eff[i]) begin
          raw_q[i] <= 1'b0; // [RQ15]
        end else if (state_d == CNT_DOWN && cnt_d <= duty_eff[i]) begin
          raw_q[i] <= 1'b1; // [RQ15]
        end
      end
    end
  end

  for (genvar p = 0; p < NUM_OUT / 2; p++) begin : g_pair
    logic [DT_W-1:0] dtc_q;
    logic [1:0] prev_q;
    logic [1:0] dto_q;
    logic [1:0] des;
    always_comb begin
      case (pair_mode_q)
        PAIR_COMP: pair_w[2*p +: 2] = {~raw_q[2*p], raw_q[2*p]}; // [RQ16]
        PAIR_SYNC: pair_w[2*p +: 2] = {raw_q[2*p], raw_q[2*p]}; // [RQ16]
        default: pair_w[2*p +: 2] = raw_q[2*p +: 2];
      endcase
    end
    assign des = pair_w[2*p +: 2];
    // any edge in the pair reloads the shared counter; rising edges wait for it to run out
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        dtc_q <= '0;
        prev_q <= 2'b00;
        dto_q <= 2'b00;
      end else begin
        prev_q <= des;
        if (des != prev_q) dtc_q <= dt_val_q;
        else if (dtc_q != '0) dtc_q <= dtc_q - 1'b1;
        dto_q <= des & (dto_q | {2{dtc_q == '0 && des == prev_q}}); // [RQ6]
      end
    end
    assign dt_w[2*p +: 2] = (pair_mode_q == PAIR_COMP && dt_en_q[p]) ? dto_q : des;
  end

  assign fb_active = fault_pin ^ fb_pol_q;
  // 8-cycle debounce: a shorter pulse on the fault pin never trips
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fb_cnt_q <= '0;
    end else if (!fb_active || !fb_en_q) begin
      fb_cnt_q <= '0;
    end else if (fb_cnt_q != FB_DEBOUNCE_CYC) begin
      fb_cnt_q <= fb_cnt_q + 1'b1;
    end
  end
  assign fb_trip = fb_en_q & fb_active & (fb_cnt_q == FB_DEBOUNCE_CYC - 4'h1);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fb_flag_q <= 1'b0;
    end else if (fb_trip) begin
      fb_flag_q <= 1'b1;
    end else if (hit(OFF_FAULT) && be[0] && wd[FAULT_FLAG]) begin
      fb_flag_q <= 1'b0;
    end
  end

  assign ctl_w = brake_q ? fb_data_q : ((mask_en_q & mask_lvl_q) | (~mask_en_q & dt_w)); // [RQ6]

  // pin direction is left to the port logic outside; only the level is chosen here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_level_q <= '0;
    end else begin
      pin_level_q <= (pin_sel_q & (ctl_w ^ inv_q)) | (~pin_sel_q & gpio_level); // [RQ6]
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_reload_at_end;
    load_q && period_end && !load_set;
  endsequence
  sequence s_up_step;
    cnt_step && state_q == CNT_UP && cnt_q < period_q;
  endsequence
  sequence s_edge_wrap;
    cnt_step && !wtype_q && state_q == CNT_UP && cnt_q >= period_q;
  endsequence

  property p_reload_clear;
    s_reload_at_end |=> !load_q;
  endproperty
  a_reload_clear: assert property (p_reload_clear) else $error("reload request not cleared"); // [RQ10]

  property p_reload_copy;
    load_apply |=> period_q == $past(period_sh_q) && duty_q[3] == $past(duty_sh_q[3]);
  endproperty
  a_reload_copy: assert property (p_reload_copy) else $error("working values not reloaded"); // [RQ9]

  property p_reload_hold;
    !load_apply |=> $stable(period_q) && $stable(duty_q[0]);
  endproperty
  a_reload_hold: assert property (p_reload_hold) else $error("working value moved without reload"); // [RQ9]

  property p_clear;
    clr_req |=> cnt_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared"); // [RQ7]

  property p_count_up;
    s_up_step |=> cnt_q == $past(cnt_q) + 1'b1 && state_q == CNT_UP;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step up"); // [RQ8]

  property p_edge_wrap;
    s_edge_wrap |=> cnt_q == '0 ##1 !run_q || cnt_q <= CNT_W'(1);
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter did not restart at zero"); // [RQ13]

  property p_center_turn;
    cnt_step && wtype_q && state_q == CNT_UP && cnt_q >= period_q && period_q != '0 |=> state_q == CNT_DOWN;
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center counter did not turn down"); // [RQ15]

  property p_edge_set;
    cnt_step && !wtype_q && cnt_d == '0 && duty_eff[1] != '0 |=> raw_q[1];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("wave not set at count zero"); // [RQ14]

  property p_edge_clear;
    cnt_step && !wtype_q && cnt_d == duty_eff[0] |=> !raw_q[0];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("wave not cleared at duty match"); // [RQ14]

  property p_group;
    group_q |-> duty_eff[2] == duty_q[0] && duty_eff[5] == duty_q[1];
  endproperty
  a_group: assert property (p_group) else $error("group duty not shared"); // [RQ4]

  property p_sync_pair;
    pair_mode_q == PAIR_SYNC && pin_sel_q[1:0] == 2'b11 && !brake_q && mask_en_q[1:0] == 2'b00
      && inv_q[1] == inv_q[0] |=> pin_level_q[1] == pin_level_q[0];
  endproperty
  a_sync_pair: assert property (p_sync_pair) else $error("synchronous pair differs"); // [RQ16]

  property p_brake_out;
    brake_q && pin_sel_q[0] |=> pin_level_q[0] == ($past(fb_data_q[0]) ^ $past(inv_q[0]));
  endproperty
  a_brake_out: assert property (p_brake_out) else $error("brake level not driven"); // [RQ6]

  property p_gpio_pass;
    !pin_sel_q[2] |=> pin_level_q[2] == $past(gpio_level[2]);
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("gpio level not passed"); // [RQ6]

endmodule

// ### bench/half_bridge_model.sv
`timescale 1ns/1ps
// gate driver load: tallies on-time of each gate and the upper/lower overlap of the three legs summed into one count
module half_bridge_model (
  input wire logic sys_clk,
  input wire logic [5:0] gate,
  input wire logic count_en,
  input wire logic desat,
  output logic fault_out,
  output logic [5:0][15:0] on_cnt,
  output logic [15:0] overlap_cnt
);
  logic en_q = 1'b0;
  // desaturation report is active high, matching the default brake polarity
  assign fault_out = desat;
  always_ff @(posedge sys_clk) begin
    en_q <= count_en;
    if (count_en) begin
      for (int i = 0; i < 6; i++) begin
        on_cnt[i] <= (en_q ? on_cnt[i] : 16'h0000) + 16'(gate[i]);
      end
      overlap_cnt <= (en_q ? overlap_cnt : 16'h0000) + 16'(gate[0] & gate[1]) +
        16'(gate[2] & gate[3]) + 16'(gate[4] & gate[5]);
    end
  end
endmodule

// ### bench/six_channel_pwm_generator_tb_top.sv
`timescale 1ns/1ps
module six_channel_pwm_generator_tb_top;
  import pwm_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  avmm_req_t av_req = '0;
  logic [31:0] av_readdata_q;
  logic av_waitrequest_q;
  logic timer_overflow = 1'b0;
  logic fault_pin;
  logic [5:0] gpio_level = 6'h20;
  logic [5:0] pin_level_q;
  logic count_en = 1'b0;
  logic desat = 1'b0;
  logic [5:0][15:0] on_cnt;
  logic [15:0] overlap_cnt;
  logic [31:0] rd;
  logic [31:0] dut [6] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0005, 32'h0000_0009, 32'h0000_000A, 32'h0000_0003};
  int edge_hi [6] = '{0, 2, 5, 9, 10, 3};
  int error_cnt = 0;
  int checks_done = 0;
  int tmr = 0;

  six_channel_pwm_generator six_channel_pwm_generator_inst (.sys_clk(sys_clk), .nrst(nrst), .av_req(av_req),
    .av_readdata_q(av_readdata_q), .av_waitrequest_q(av_waitrequest_q), .timer_overflow(timer_overflow),
    .fault_pin(fault_pin), .gpio_level(gpio_level), .pin_level_q(pin_level_q));
  half_bridge_model half_bridge_model_inst (.sys_clk(sys_clk), .gate(pin_level_q), .count_en(count_en),
    .desat(desat), .fault_out(fault_pin), .on_cnt(on_cnt), .overlap_cnt(overlap_cnt));

  initial forever #2 sys_clk = ~sys_clk;

  // overflow every third cycle so the timer source is told apart from any ratio
  always @(posedge sys_clk) begin
    tmr <= (tmr == 2) ? 0 : tmr + 1;
    timer_overflow <= (tmr == 2);
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp, input int ch);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t pin %0d high %0d cycles expected %0d", $time, ch, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low, read data taken at that edge
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    av_req <= '{read: !wr_en, write: wr_en, address: a, byteenable: 4'hF, writedata: d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (av_waitrequest_q !== 1'b0 && n < 100);
    rd = av_readdata_q;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    if (n >= 100) chk_reg(32'hDEAD_0000, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk_reg(rd, e);
  endtask

  // no control write is issued until the request bit reads back clear
  task automatic reload(input logic [31:0] c);
    int n;
    n = 0;
    wr(OFF_CTRL0, c);
    do begin
      bus(1'b0, OFF_CTRL0, 32'h0000_0000);
      n++;
    end while (rd[CTRL0_LOAD] !== 1'b0 && n < 200);
    chk_reg(32'(rd[CTRL0_LOAD]), 32'h0000_0000);
  endtask

  // window of ten whole periods, so the phase at which counting starts does not matter
  task automatic meas(input int cpt, input int tpp, input int hi [6]);
    repeat (2 * tpp * cpt + 4) @(posedge sys_clk);
    count_en <= 1'b1;
    repeat (10 * tpp * cpt) @(posedge sys_clk);
    count_en <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) chk_cnt(on_cnt[i], 16'(10 * cpt * hi[i]), i);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(OFF_CTRL1, 32'h0000_0000);
    rdc(OFF_PERIOD, 32'h0000_0000);
    rdc(OFF_DUTY[3], 32'h0000_0000);
    rdc(OFF_COUNT, 32'h0001_0000);
    rdc(8'h3C, 32'h0000_0000);
    $display("test reset done");
    wr(OFF_CTRL0, 32'h0000_0010);
    wr(OFF_PERIOD, 32'h0000_0009);
    for (int i = 0; i < 6; i++) wr(OFF_DUTY[i], dut[i]);
    wr(OFF_OUTCFG, 32'h0000_3F00);
    reload(32'h0000_0040);
    wr(OFF_CTRL0, 32'h0000_0080);
    meas(1, 10, edge_hi);
    wr(OFF_CLKDIV, 32'h0000_0002);
    meas(4, 10, edge_hi);
    wr(OFF_CLKDIV, 32'h0000_0008);
    meas(3, 10, edge_hi);
    wr(OFF_CLKDIV, 32'h0000_0000);
    wr(OFF_CTRL1, 32'h0000_0020);
    meas(1, 10, '{0, 2, 0, 2, 0, 2});
    wr(OFF_CTRL1, 32'h0000_0000);
    $display("test edge done");
    wr(OFF_CTRL0, 32'h0000_0000);
    wr(OFF_CTRL0, 32'h0000_0010);
    rdc(OFF_COUNT, 32'h0001_0000);
    wr(OFF_CTRL0, 32'h0000_0080);
    wr(OFF_DUTY[0], 32'h0000_0007);
    wr(OFF_PERIOD, 32'h0000_0008);
    rdc(OFF_DUTY[0], 32'h0000_0007);
    meas(1, 10, edge_hi);
    reload(32'h0000_00C0);
    $display("test reload done");
    wr(OFF_CTRL1, 32'h0000_0010);
    meas(1, 16, '{14, 4, 10, 16, 16, 6});
    wr(OFF_CTRL1, 32'h0000_0050);
    meas(1, 16, '{14, 2, 10, 6, 16, 0});
    chk_cnt(overlap_cnt, 16'h0000, 0);
    // dead time of one clock on pair 0 costs each high phase two clocks
    wr(OFF_DEADTIME, 32'h0001_0001);
    meas(1, 16, '{12, 0, 10, 6, 16, 0});
    chk_cnt(overlap_cnt, 16'h0000, 0);
    wr(OFF_CTRL1, 32'h0000_0090);
    meas(1, 16, '{14, 14, 10, 10, 16, 16});
    wr(OFF_CTRL1, 32'h0000_0010);
    wr(OFF_MASK, 32'h0000_0202);
    wr(OFF_OUTCFG, 32'h0000_1F01);
    meas(1, 16, '{2, 16, 10, 16, 16, 16});
    $display("test center and output stage done");
    wr(OFF_OUTCFG, 32'h0000_3F00);
    wr(OFF_MASK, 32'h0000_0000);
    wr(OFF_CTRL1, 32'h0000_0018);
    desat <= 1'b1;
    repeat (12) @(posedge sys_clk);
    desat <= 1'b0;
    rdc(OFF_CTRL0, 32'h0000_0000);
    rdc(OFF_FAULT, 32'h0000_0080);
    meas(1, 16, '{0, 0, 0, 0, 0, 0});
    // clearing the flag must not release the brake; only a run write does
    wr(OFF_FAULT, 32'h0000_0080);
    rdc(OFF_FAULT, 32'h0000_0000);
    meas(1, 16, '{0, 0, 0, 0, 0, 0});
    wr(OFF_CTRL0, 32'h0000_0080);
    meas(1, 16, '{14, 4, 10, 16, 16, 6});
    $display("test brake done");
    summarize();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule
